// [rtl/vacuum_grip_pkg.sv]
package vacuum_grip_pkg;

	// ====================================================================
	// byte offsets: status bytes are read, request bytes are written
	localparam logic [3:0] ADDR_GRIP_STATUS      = 4'h0;
	localparam logic [3:0] ADDR_ACTUATOR_STATUS  = 4'h1;
	localparam logic [3:0] ADDR_FAULT_STATUS     = 4'h2;
	localparam logic [3:0] ADDR_MAX_LEVEL_ECHO   = 4'h3;
	localparam logic [3:0] ADDR_MEASURED_PRESS   = 4'h4;
	localparam logic [3:0] ADDR_ACTION_REQUEST   = 4'h0;
	localparam logic [3:0] ADDR_MAX_LEVEL_REQ    = 4'h3;
	localparam logic [3:0] ADDR_TIMEOUT_SETTING  = 4'h4;
	localparam logic [3:0] ADDR_MIN_LEVEL_REQ    = 4'h5;

	// ====================================================================
	// reset values and pressure levels (value 100 is ambient)
	localparam logic [7:0] REQUEST_RESET  = 8'h00;
	localparam logic [7:0] LEVEL_AMBIENT  = 8'h64;
	localparam logic [7:0] LEVEL_VAC_10   = 8'h5a;
	localparam logic [7:0] LEVEL_VAC_30   = 8'h46;
	localparam logic [7:0] LEVEL_FULL_VAC = 8'h00;

	// ====================================================================
	// codes
	localparam logic [1:0] MODE_AUTO      = 2'h0;
	localparam logic [1:0] MODE_ADVANCED  = 2'h1;
	localparam logic [1:0] OBJ_UNKNOWN    = 2'h0;
	localparam logic [1:0] OBJ_AT_MIN     = 2'h1;
	localparam logic [1:0] OBJ_AT_MAX     = 2'h2;
	localparam logic [1:0] OBJ_NONE       = 2'h3;
	localparam logic [1:0] ACT_STANDBY    = 2'h0;
	localparam logic [1:0] ACT_GRIPPING   = 2'h1;
	localparam logic [1:0] ACT_PASSIVE    = 2'h2;
	localparam logic [1:0] ACT_ACTIVE     = 2'h3;
	localparam logic [1:0] ACTIVATION_OFF = 2'h0;
	localparam logic [1:0] ACTIVATION_ON  = 2'h3;
	localparam logic [3:0] FLT_NONE       = 4'h0;
	localparam logic [3:0] FLT_POROUS     = 4'h3;
	localparam logic [3:0] FLT_DELAYED    = 4'h5;
	localparam logic [3:0] FLT_GRIP_TMO   = 4'h6;
	localparam logic [3:0] FLT_NOT_ACTIVE = 4'h7;
	localparam logic [3:0] FLT_OVER_TEMP  = 4'h8;
	localparam logic [3:0] FLT_COMM_LOSS  = 4'h9;
	localparam logic [3:0] FLT_UNDER_VOLT = 4'ha;
	localparam logic [3:0] FLT_AREL_BUSY  = 4'hb;
	localparam logic [3:0] FLT_INTERNAL   = 4'hc;
	localparam logic [3:0] FLT_AREL_DONE  = 4'hf;

	// ====================================================================
	// times in milliseconds and the clock rate
	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
	localparam int unsigned AUTO_GRIP_MS    = 2000;
	localparam int unsigned COMM_LOSS_MS    = 1000;
	localparam int unsigned AUTO_LOW_MS     = 1000;
	localparam int unsigned ADV_LOW_MS      = 100;
	localparam int unsigned TIMEOUT_STEP_MS = 100;
	localparam int unsigned RELEASE_HOLD_MS = 100;
	localparam int unsigned POROUS_MS       = 50;

	// ====================================================================
	// types
	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_GRIP     = 3'b001,
		ST_HOLD     = 3'b010,
		ST_RELEASE  = 3'b011,
		ST_REL_HOLD = 3'b100,
		ST_TIMEOUT  = 3'b101,
		ST_AUTO_REL = 3'b110,
		ST_DONE     = 3'b111
	} grip_state_e;

	typedef struct packed {
		logic [2:0] spare;
		logic       auto_release;
		logic       regulate_request;
		logic [1:0] mode_select;
		logic       activate_request;
	} action_s;

endpackage

// [rtl/vacuum_gripper_status_regulation.sv]
`timescale 1ns/1ps
module vacuum_gripper_status_regulation
	import vacuum_grip_pkg::*;
#(
	parameter int unsigned AUTO_GRIP_CYCLES = AUTO_GRIP_MS * MS_CYCLES,
	parameter int unsigned COMM_LOSS_CYCLES = COMM_LOSS_MS * MS_CYCLES,
	parameter int unsigned AUTO_LOW_CYCLES  = AUTO_LOW_MS * MS_CYCLES,
	parameter int unsigned ADV_LOW_CYCLES   = ADV_LOW_MS * MS_CYCLES,
	parameter int unsigned STEP_CYCLES      = TIMEOUT_STEP_MS * MS_CYCLES,
	parameter int unsigned REL_HOLD_CYCLES  = RELEASE_HOLD_MS * MS_CYCLES,
	parameter int unsigned POROUS_CYCLES    = POROUS_MS * MS_CYCLES
)
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// request byte writes
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// status byte reads
	input  wire logic       rd_en,
	input  wire logic [3:0] rd_addr,
	output logic      [7:0] rd_data,
	// sensors
	input  wire logic [7:0] pressure_sample,
	input  wire logic       over_temp_pin,
	input  wire logic       under_volt_pin,
	input  wire logic       internal_fault_pin,
	// actuators
	output logic            generator_on,
	output logic            release_valve_open,
	output logic            pressure_valve_open
);

	// ====================================================================
	// request storage and status signals
	action_s     action_reg;
	logic [7:0]  max_req_reg;
	logic [7:0]  timeout_reg;
	logic [7:0]  min_req_reg;
	logic        settings_chg_reg;
	logic [7:0]  press_reg;
	logic [2:0]  sync1_reg;
	logic [2:0]  sync2_reg;
	logic        act_prev_reg;
	grip_state_e state_reg;
	logic [31:0] timer_reg;
	logic [31:0] low_cnt_reg;
	logic [31:0] off_cnt_reg;
	logic [31:0] comm_cnt_reg;
	logic        comm_lost_reg;
	logic        porous_reg;
	logic        delayed_reg;
	logic        hold_gen_reg;
	logic        continuous_reg;
	logic [7:0]  hi_lvl_reg;
	logic [7:0]  lo_lvl_reg;
	logic [7:0]  peak_reg;
	logic [1:0]  object_reg;
	logic [3:0]  major_reg;
	logic [1:0]  actuator_reg;
	logic [1:0]  actuator_next;
	logic [3:0]  fault_code;
	logic [7:0]  rd_data_reg;
	logic        run;
	logic        grip_cmd;
	logic        adv_mode;
	logic        act_rise;
	logic        regulating;
	logic [31:0] grip_limit;
	logic [31:0] low_limit;
	logic [31:0] rel_limit;
	logic [7:0]  derived_lo;

	assign adv_mode   = action_reg.mode_select == MODE_ADVANCED;
	assign grip_cmd   = max_req_reg < LEVEL_AMBIENT;
	assign run        = action_reg.activate_request
		& action_reg.regulate_request
		& (action_reg.mode_select == MODE_AUTO || adv_mode);
	assign act_rise   = action_reg.activate_request & ~act_prev_reg;
	assign regulating = state_reg == ST_GRIP || state_reg == ST_HOLD
		|| state_reg == ST_RELEASE || state_reg == ST_REL_HOLD;
	// 100 ms steps; advanced only
	assign grip_limit = adv_mode ? 32'(timeout_reg) * STEP_CYCLES
		: AUTO_GRIP_CYCLES;
	assign low_limit  = adv_mode ? ADV_LOW_CYCLES : AUTO_LOW_CYCLES;
	assign rel_limit  = adv_mode ? 32'(timeout_reg) * STEP_CYCLES
		: REL_HOLD_CYCLES;
	// min level a quarter of the way back from the peak toward ambient
	assign derived_lo = peak_reg + 8'((LEVEL_AMBIENT - peak_reg) >> 2);

	// ====================================================================
	// request writes; status bytes have no write path at all
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			action_reg       <= action_s'(REQUEST_RESET);
			max_req_reg      <= REQUEST_RESET;
			timeout_reg      <= REQUEST_RESET;
			min_req_reg      <= REQUEST_RESET;
			settings_chg_reg <= 1'b0;
		end
		else
		begin
			settings_chg_reg <= 1'b0;
			if (wr_en && wr_addr == ADDR_ACTION_REQUEST)
			begin
				action_reg       <= action_s'(wr_data);
				settings_chg_reg <= wr_data[2:1] != action_reg.mode_select;
			end
			else if (wr_en && wr_addr == ADDR_MAX_LEVEL_REQ)
			begin
				max_req_reg      <= wr_data;
				settings_chg_reg <= wr_data != max_req_reg;
			end
			else if (wr_en && wr_addr == ADDR_TIMEOUT_SETTING)
			begin
				timeout_reg      <= wr_data;
				settings_chg_reg <= wr_data != timeout_reg;
			end
			else if (wr_en && wr_addr == ADDR_MIN_LEVEL_REQ)
			begin
				min_req_reg      <= wr_data;
				settings_chg_reg <= wr_data != min_req_reg;
			end
		end
	end

	// ====================================================================
	// sensor capture; fault pins are asynchronous, two stages each
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_reg    <= 3'h0;
			sync2_reg    <= 3'h0;
			press_reg    <= LEVEL_AMBIENT;
			act_prev_reg <= 1'b0;
		end
		else
		begin
			sync1_reg    <= {internal_fault_pin, under_volt_pin, over_temp_pin};
			sync2_reg    <= sync1_reg;
			press_reg    <= pressure_sample;
			act_prev_reg <= action_reg.activate_request;
		end
	end

	// ====================================================================
	// grip and release sequencer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg      <= ST_IDLE;
			timer_reg      <= 32'h0;
			low_cnt_reg    <= 32'h0;
			hold_gen_reg   <= 1'b0;
			continuous_reg <= 1'b0;
			hi_lvl_reg     <= LEVEL_FULL_VAC;
			lo_lvl_reg     <= LEVEL_VAC_10;
			peak_reg       <= LEVEL_AMBIENT;
			object_reg     <= OBJ_UNKNOWN;
		end
		else if (!action_reg.activate_request)
			state_reg <= ST_IDLE;
		else if (action_reg.auto_release)
			state_reg <= ST_AUTO_REL;
		else if (!action_reg.regulate_request)
			state_reg <= ST_IDLE;
		else
		begin
			timer_reg <= timer_reg + 32'h1;
			case (state_reg)
			ST_IDLE, ST_DONE:
				if (run && grip_cmd)
				begin
					state_reg      <= ST_GRIP;
					timer_reg      <= 32'h0;
					object_reg     <= OBJ_UNKNOWN;
					peak_reg       <= press_reg;
					hi_lvl_reg     <= adv_mode ? max_req_reg : LEVEL_FULL_VAC;
					lo_lvl_reg     <= adv_mode ? min_req_reg : LEVEL_VAC_10;
					// a full vacuum target can never be met
					continuous_reg <= adv_mode && max_req_reg == LEVEL_FULL_VAC;
				end
				else if (run && state_reg == ST_IDLE)
					state_reg <= ST_RELEASE;
			ST_GRIP:
			begin
				if (press_reg < peak_reg)
					peak_reg <= press_reg;
				if (!grip_cmd)
					state_reg <= ST_RELEASE;
				else if (!adv_mode && timer_reg >= grip_limit)
				begin
					state_reg   <= ST_HOLD;
					low_cnt_reg <= 32'h0;
					if (peak_reg > LEVEL_VAC_30)
					begin
						continuous_reg <= 1'b1;
						hold_gen_reg   <= 1'b1;
						object_reg     <= OBJ_AT_MIN;
					end
					else
					begin
						hi_lvl_reg   <= peak_reg;
						lo_lvl_reg   <= derived_lo;
						hold_gen_reg <= 1'b0;
						object_reg   <= OBJ_AT_MAX;
					end
				end
				else if (adv_mode && !continuous_reg
					&& press_reg <= hi_lvl_reg)
				begin
					state_reg    <= ST_HOLD;
					low_cnt_reg  <= 32'h0;
					hold_gen_reg <= 1'b0;
					object_reg   <= OBJ_AT_MAX;
				end
				else if (adv_mode && press_reg <= lo_lvl_reg)
				begin
					state_reg    <= ST_HOLD;
					low_cnt_reg  <= 32'h0;
					hold_gen_reg <= 1'b1;
					object_reg   <= OBJ_AT_MIN;
				end
				else if (adv_mode && timeout_reg != 8'h0
					&& timer_reg >= grip_limit)
				begin
					state_reg  <= ST_TIMEOUT;
					object_reg <= OBJ_NONE;
				end
			end
			ST_HOLD:
			begin
				low_cnt_reg <= press_reg > lo_lvl_reg ? low_cnt_reg + 32'h1
					: 32'h0;
				if (!grip_cmd)
					state_reg <= ST_RELEASE;
				else if (press_reg > LEVEL_VAC_10
					|| low_cnt_reg > low_limit)
				begin
					state_reg  <= ST_GRIP;
					timer_reg  <= 32'h0;
					peak_reg   <= press_reg;
					object_reg <= OBJ_UNKNOWN;
				end
				else if (!continuous_reg && press_reg <= hi_lvl_reg)
				begin
					hold_gen_reg <= 1'b0;
					object_reg   <= OBJ_AT_MAX;
				end
				else if (press_reg >= lo_lvl_reg && !hold_gen_reg)
				begin
					hold_gen_reg <= 1'b1;
					object_reg   <= OBJ_AT_MIN;
				end
			end
			ST_RELEASE:
				if (press_reg >= LEVEL_AMBIENT)
				begin
					state_reg  <= ST_REL_HOLD;
					timer_reg  <= 32'h0;
					object_reg <= OBJ_NONE;
				end
			ST_REL_HOLD:
				if (timer_reg >= rel_limit)
					state_reg <= ST_DONE;
			ST_TIMEOUT:
				if (settings_chg_reg)
					state_reg <= ST_IDLE;
			default:
				state_reg <= ST_IDLE;
			endcase
		end
	end

	// ====================================================================
	// actuator drive; release strength follows the request value, auto release is always passive
	always_comb
	begin
		case (state_reg)
		ST_GRIP:
			actuator_next = ACT_GRIPPING;
		ST_HOLD:
			actuator_next = hold_gen_reg ? ACT_GRIPPING : ACT_STANDBY;
		ST_RELEASE, ST_REL_HOLD:
			actuator_next = max_req_reg == LEVEL_AMBIENT ? ACT_PASSIVE
				: ACT_ACTIVE;
		ST_AUTO_REL:
			actuator_next = ACT_PASSIVE;
		default:
			actuator_next = ACT_STANDBY;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			actuator_reg        <= ACT_STANDBY;
			generator_on        <= 1'b0;
			release_valve_open  <= 1'b0;
			pressure_valve_open <= 1'b0;
		end
		else
		begin
			actuator_reg        <= actuator_next;
			generator_on        <= actuator_next == ACT_GRIPPING;
			release_valve_open  <= actuator_next[1];
			pressure_valve_open <= actuator_next == ACT_ACTIVE;
		end
	end

	// ====================================================================
	// fault sources
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			comm_cnt_reg  <= 32'h0;
			comm_lost_reg <= 1'b0;
			off_cnt_reg   <= 32'h0;
			porous_reg    <= 1'b0;
			delayed_reg   <= 1'b0;
			major_reg     <= FLT_NONE;
		end
		else
		begin
			// any access ends the silence; a read sees fault 9 once
			if (rd_en || wr_en)
			begin
				comm_cnt_reg  <= 32'h0;
				comm_lost_reg <= 1'b0;
			end
			else if (comm_cnt_reg >= COMM_LOSS_CYCLES)
				comm_lost_reg <= 1'b1;
			else
				comm_cnt_reg <= comm_cnt_reg + 32'h1;
			// restart too soon after stopping means leaky material
			off_cnt_reg <= actuator_reg == ACT_STANDBY ? off_cnt_reg + 32'h1
				: 32'h0;
			if (adv_mode && state_reg == ST_HOLD && actuator_reg == ACT_STANDBY
				&& actuator_next == ACT_GRIPPING && off_cnt_reg < POROUS_CYCLES)
				porous_reg <= 1'b1;
			else if (state_reg == ST_IDLE)
				porous_reg <= 1'b0;
			// a grip asked for during release waits for the hold to end
			if (grip_cmd && (state_reg == ST_RELEASE
				|| state_reg == ST_REL_HOLD))
				delayed_reg <= 1'b1;
			else if (state_reg != ST_RELEASE && state_reg != ST_REL_HOLD)
				delayed_reg <= 1'b0;
			// major codes latch; set wins over the activate edge
			if (sync2_reg[1])
				major_reg <= FLT_UNDER_VOLT;
			else if (sync2_reg[2])
				major_reg <= FLT_INTERNAL;
			else if (state_reg == ST_AUTO_REL && major_reg != FLT_AREL_DONE)
				major_reg <= press_reg >= LEVEL_AMBIENT ? FLT_AREL_DONE
					: FLT_AREL_BUSY;
			else if (act_rise)
				major_reg <= FLT_NONE;
		end
	end

	always_comb
	begin
		if (major_reg != FLT_NONE)
			fault_code = major_reg;
		else if (comm_lost_reg)
			fault_code = FLT_COMM_LOSS;
		else if (sync2_reg[0])
			fault_code = FLT_OVER_TEMP;
		else if (action_reg.regulate_request
			&& !action_reg.activate_request)
			fault_code = FLT_NOT_ACTIVE;
		else if (state_reg == ST_TIMEOUT)
			fault_code = FLT_GRIP_TMO;
		else if (delayed_reg)
			fault_code = FLT_DELAYED;
		else if (porous_reg)
			fault_code = FLT_POROUS;
		else
			fault_code = FLT_NONE;
	end

	// ====================================================================
	// status byte reads; unmapped offsets and spare bits read zero
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_reg <= 8'h00;
		else if (rd_en)
		begin
			if (rd_addr == ADDR_GRIP_STATUS)
				rd_data_reg <= {object_reg,
					act_prev_reg ? ACTIVATION_ON : ACTIVATION_OFF,
					action_reg.regulate_request & regulating,
					action_reg.mode_select,
					action_reg.activate_request};
			else if (rd_addr == ADDR_ACTUATOR_STATUS)
				rd_data_reg <= {6'h00, actuator_reg};
			else if (rd_addr == ADDR_FAULT_STATUS)
				rd_data_reg <= {4'h0, fault_code};
			else if (rd_addr == ADDR_MAX_LEVEL_ECHO)
				rd_data_reg <= max_req_reg;
			else if (rd_addr == ADDR_MEASURED_PRESS)
				rd_data_reg <= press_reg;
			else
				rd_data_reg <= 8'h00;
		end
	end

	assign rd_data = rd_data_reg;

	// ====================================================================
	// checks
	AST_ACT_ECHO: assert property (@(posedge clock) disable iff (!rst_n)
		rd_en && rd_addr == ADDR_GRIP_STATUS
		|=> rd_data_reg[0] == $past(action_reg.activate_request))
		else $error("activate echo differs from request");
	AST_MAX_ECHO: assert property (@(posedge clock) disable iff (!rst_n)
		rd_en && rd_addr == ADDR_MAX_LEVEL_ECHO
		|=> rd_data_reg == $past(max_req_reg))
		else $error("max level echo differs from request");
	AST_RSVD_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		rd_en && rd_addr == ADDR_ACTUATOR_STATUS |=> rd_data_reg[7:2] == 6'h0)
		else $error("reserved actuator bits not zero");
	AST_NOT_ACTIVE: assert property (@(posedge clock) disable iff (!rst_n)
		action_reg.regulate_request && !action_reg.activate_request
		&& major_reg == FLT_NONE && !comm_lost_reg && !sync2_reg[0]
		|-> fault_code == FLT_NOT_ACTIVE)
		else $error("missing not-activated fault");
	AST_REG_LOW: assert property (@(posedge clock) disable iff (!rst_n)
		(!action_reg.regulate_request && !action_reg.auto_release)[*2]
		|=> actuator_reg == ACT_STANDBY)
		else $error("actuators busy with regulate low");
	AST_RO: assert property (@(posedge clock) disable iff (!rst_n)
		wr_en && wr_addr == ADDR_ACTUATOR_STATUS
		|=> $stable(action_reg) && $stable(max_req_reg))
		else $error("status write changed a request");
	AST_PRESS: assert property (@(posedge clock) disable iff (!rst_n)
		rd_en && rd_addr == ADDR_MEASURED_PRESS
		|=> rd_data_reg == $past(pressure_sample, 2))
		else $error("measured pressure byte wrong");
	AST_DROP: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == ST_RELEASE && press_reg >= LEVEL_AMBIENT
		&& action_reg.regulate_request && action_reg.activate_request
		&& !action_reg.auto_release |=> object_reg == OBJ_NONE
		##0 state_reg == ST_REL_HOLD)
		else $error("release did not flag drop");
	AST_MAJOR: assert property (@(posedge clock) disable iff (!rst_n)
		major_reg != FLT_NONE && state_reg != ST_AUTO_REL && !act_rise
		&& sync2_reg[2:1] == 2'h0 |=> $stable(major_reg))
		else $error("major fault cleared without activate edge");
	AST_TMO: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == ST_TIMEOUT |-> object_reg == OBJ_NONE
		&& actuator_next == ACT_STANDBY)
		else $error("timeout state inconsistent");
	COV_GRIP: cover property (@(posedge clock) disable iff (!rst_n)
		state_reg == ST_GRIP ##1 state_reg == ST_HOLD);
	COV_RELEASE: cover property (@(posedge clock) disable iff (!rst_n)
		state_reg == ST_REL_HOLD ##1 state_reg == ST_DONE);
	COV_TIMEOUT: cover property (@(posedge clock) disable iff (!rst_n)
		state_reg == ST_TIMEOUT);

endmodule

// [verif/ctrl_model.sv]
`timescale 1ns/1ps
// ====================
// controller side: byte strobes, one access at a time
module ctrl_model
(
	// clock
	input  wire logic       clock,
	// requests
	output logic            wr_en,
	output logic      [3:0] wr_addr,
	output logic      [7:0] wr_data,
	output logic            rd_en,
	output logic      [3:0] rd_addr,
	// answer
	input  wire logic [7:0] rd_data
);
	initial
	begin
		wr_en = 1'b0;
		wr_addr = 4'h0;
		wr_data = 8'h00;
		rd_en = 1'b0;
		rd_addr = 4'h0;
	end
	// request held until the edge that takes it
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	// data registered on the taking edge, sampled once settled
	task automatic rd(input logic [3:0] a, output logic [7:0] q);
		@(posedge clock);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		@(posedge clock);
		#1 q = rd_data;
	endtask
	// activate low then high, before any action
	task automatic activate(input logic [7:0] d);
		wr(4'h0, 8'h00);
		wr(4'h0, d);
	endtask
endmodule

// [verif/vacuum_gripper_status_regulation_bench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module vacuum_gripper_status_regulation_bench;
	import vacuum_grip_pkg::*;
	logic       clock = 1'b0;
	logic       rst_n = 1'b0;
	logic       wr_en, rd_en;
	logic [3:0] wr_addr, rd_addr;
	logic [7:0] wr_data, rd_data;
	logic [7:0] pressure_sample = 8'h64;
	logic       over_temp_pin = 1'b0;
	logic       under_volt_pin = 1'b0;
	logic       internal_fault_pin = 1'b0;
	logic       gen_on, rel_open, prs_open;
	int         errors = 0;
	int         compares = 0;
	int         cycles = 0;
	always #50 clock = ~clock;
	ctrl_model ctrl_u (.clock(clock), .wr_en(wr_en), .wr_addr(wr_addr),
		.wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
		.rd_data(rd_data));
	// slow automatic hold times keep their defaults; no test waits on them
	vacuum_gripper_status_regulation #(.AUTO_GRIP_CYCLES(200),
		.COMM_LOSS_CYCLES(300), .ADV_LOW_CYCLES(20), .STEP_CYCLES(10),
		.POROUS_CYCLES(5)) dut_u (.clock(clock), .rst_n(rst_n),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
		.pressure_sample(pressure_sample), .over_temp_pin(over_temp_pin),
		.under_volt_pin(under_volt_pin),
		.internal_fault_pin(internal_fault_pin),
		.generator_on(gen_on), .release_valve_open(rel_open),
		.pressure_valve_open(prs_open));
	task automatic test_done;
		if (errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clock)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			errors++;
			test_done;
		end
	end
	task automatic rc(input logic [3:0] a, input logic [7:0] m, e);
		logic [7:0] q;
		ctrl_u.rd(a, q);
		`CHK(q & m, e)
	endtask
	task automatic press(input logic [7:0] v);
		@(posedge clock);
		pressure_sample <= v;
		repeat (4) @(posedge clock);
	endtask
	initial
	begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		rc(4'h0, 8'h3f, 8'h00);
		rc(4'h1, 8'hff, ACT_STANDBY);
		rc(4'h3, 8'hff, REQUEST_RESET);
		rc(4'h4, 8'hff, LEVEL_AMBIENT);
		rc(4'h5, 8'hff, 8'h00);
		ctrl_u.wr(4'h1, 8'hff);
		ctrl_u.wr(4'h2, 8'hff);
		rc(4'h1, 8'hff, 8'h00);
		rc(4'h2, 8'hff, FLT_NONE);
		ctrl_u.wr(4'h0, 8'h0a);
		rc(4'h2, 8'hff, FLT_NOT_ACTIVE);
		ctrl_u.activate(8'h01);
		rc(4'h0, 8'h3f, 8'h31);
		// advanced grip: max 22, min 80, timeout five steps
		ctrl_u.wr(4'h3, 8'h16);
		ctrl_u.wr(4'h5, 8'h50);
		ctrl_u.wr(4'h4, 8'h05);
		rc(4'h3, 8'hff, 8'h16);
		ctrl_u.wr(4'h0, 8'h0b);
		// actuator status trails the state by one edge
		@(posedge clock);
		rc(4'h1, 8'hff, ACT_GRIPPING);
		`CHK(gen_on, 1'b1)
		rc(4'h0, 8'hff, 8'h3b);
		press(8'h10);
		rc(4'h0, 8'hff, 8'hbb);
		press(8'h50);
		rc(4'h0, 8'hff, 8'h7b);
		rc(4'h4, 8'hff, 8'h50);
		ctrl_u.wr(4'h3, LEVEL_AMBIENT);
		@(posedge clock);
		rc(4'h1, 8'hff, ACT_PASSIVE);
		`CHK(rel_open, 1'b1)
		`CHK(prs_open, 1'b0)
		press(LEVEL_AMBIENT);
		rc(4'h0, 8'hff, 8'hfb);
		repeat (60) @(posedge clock);
		rc(4'h1, 8'hff, ACT_STANDBY);
		// grip that never reaches min times out after five steps
		ctrl_u.wr(4'h3, 8'h16);
		repeat (70) @(posedge clock);
		rc(4'h2, 8'hff, FLT_GRIP_TMO);
		rc(4'h0, 8'hff, 8'hf3);
		ctrl_u.wr(4'h0, 8'h03);
		ctrl_u.wr(4'h0, 8'h0b);
		rc(4'h2, 8'hff, FLT_NONE);
		// a second timeout, cleared this time by a new timeout setting
		repeat (70) @(posedge clock);
		rc(4'h2, 8'hff, FLT_GRIP_TMO);
		ctrl_u.wr(4'h4, 8'h06);
		rc(4'h2, 8'hff, FLT_NONE);
		ctrl_u.wr(4'h0, 8'h03);
		@(posedge clock);
		rc(4'h1, 8'hff, ACT_STANDBY);
		`CHK(gen_on, 1'b0)
		rc(4'h0, 8'h3f, 8'h33);
		@(posedge clock);
		over_temp_pin <= 1'b1;
		repeat (5) @(posedge clock);
		rc(4'h2, 8'hff, FLT_OVER_TEMP);
		@(posedge clock);
		over_temp_pin <= 1'b0;
		repeat (5) @(posedge clock);
		rc(4'h2, 8'hff, FLT_NONE);
		// silence longer than the comm-loss count, shown once
		repeat (310) @(posedge clock);
		rc(4'h2, 8'hff, FLT_COMM_LOSS);
		rc(4'h2, 8'hff, FLT_NONE);
		press(8'h30);
		ctrl_u.wr(4'h0, 8'h13);
		// the major code latches one edge after the state changes
		@(posedge clock);
		rc(4'h2, 8'hff, FLT_AREL_BUSY);
		rc(4'h1, 8'hff, ACT_PASSIVE);
		press(LEVEL_AMBIENT);
		rc(4'h2, 8'hff, FLT_AREL_DONE);
		ctrl_u.wr(4'h0, 8'h01);
		rc(4'h2, 8'hff, FLT_AREL_DONE);
		ctrl_u.activate(8'h01);
		rc(4'h2, 8'hff, FLT_NONE);
		// automatic grip peaking under 30% vacuum runs continuously
		press(8'h50);
		ctrl_u.wr(4'h0, 8'h09);
		repeat (210) @(posedge clock);
		rc(4'h0, 8'hff, 8'h79);
		`CHK(gen_on, 1'b1)
		ctrl_u.wr(4'h0, 8'h01);
		// deeper peak: own levels, object at max, generator resting
		press(8'h30);
		ctrl_u.wr(4'h0, 8'h09);
		repeat (210) @(posedge clock);
		rc(4'h0, 8'hff, 8'hb9);
		`CHK(gen_on, 1'b0)
		press(8'h60);
		rc(4'h0, 8'hff, 8'h39);
		ctrl_u.wr(4'h3, 8'h65);
		@(posedge clock);
		rc(4'h1, 8'hff, ACT_ACTIVE);
		`CHK(prs_open, 1'b1)
		press(LEVEL_AMBIENT);
		rc(4'h0, 8'hff, 8'hf9);
		ctrl_u.wr(4'h0, 8'h01);
		// asynchronous major faults, each cleared by an activate edge
		@(posedge clock);
		under_volt_pin <= 1'b1;
		repeat (4) @(posedge clock);
		under_volt_pin <= 1'b0;
		rc(4'h2, 8'hff, FLT_UNDER_VOLT);
		ctrl_u.activate(8'h01);
		rc(4'h2, 8'hff, FLT_NONE);
		@(posedge clock);
		internal_fault_pin <= 1'b1;
		repeat (4) @(posedge clock);
		internal_fault_pin <= 1'b0;
		rc(4'h2, 8'hff, FLT_INTERNAL);
		ctrl_u.activate(8'h01);
		rc(4'h2, 8'hff, FLT_NONE);
		test_done;
	end
endmodule
